// [common/dmmod_pkg.sv]
// Shared constants and types of the memory map and overlay decoder
package dmmod_pkg;
    // ****************************************
    // Address widths and map boundaries
    // ****************************************
    localparam int          ADDR_W        = 14;
    localparam int          IO_ADDR_W     = 11;
    localparam int          PM_W          = 24;
    localparam int          REG_AW        = 4;
    localparam int          REG_DW        = 16;
    localparam int          PM_DEPTH      = 16384;
    localparam logic [13:0] DM_MMR_BASE   = 14'h3FE0;
    localparam logic [3:0]  OVL_NONE      = 4'h0;
    localparam logic [3:0]  OVL_ONE       = 4'h1;
    localparam logic [3:0]  OVL_TWO       = 4'h2;
    localparam int          WAIT_W        = 3;
    localparam int          SYNC_CYCLES   = 3;

    // ****************************************
    // Register offsets (word index)
    // ****************************************
    localparam logic [3:0]  REG_PM_OVL    = 4'h0;
    localparam logic [3:0]  REG_DM_OVL    = 4'h1;
    localparam logic [3:0]  REG_DATA_WAIT_COUNT     = 4'h2;
    localparam logic [3:0]  REG_IOWAIT    = 4'h3;
    localparam logic [3:0]  REG_MSW       = 4'h4;
    localparam logic [3:0]  REG_STATUS    = 4'h5;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int          ST_RUN_BIT    = 0;
    localparam int          ST_BOOT_BIT   = 1;
    localparam int          ST_MEMORY_MAP_SELECT_PIN_BIT   = 2;
    localparam int          ST_OVLERR_BIT = 3;
    localparam logic [3:0]  OVL_RST       = 4'h0;
    localparam logic [2:0]  DATA_WAIT_COUNT_RST     = 3'h0;
    localparam logic [11:0] IOWAIT_RST    = 12'h000;
    localparam logic [7:0]  MSW_RST       = 8'h00;

    typedef enum logic [1:0] {
        DMMOD_SYNC,
        DMMOD_DECIDE,
        DMMOD_BOOT,
        DMMOD_RUN
    } dmmod_boot_e;
endpackage

// [src/dmmod_pm_ram.sv]
// Program RAM with one write port and two independent read ports
`timescale 1ns/1ps
module dmmod_pm_ram
    import dmmod_pkg::*;
#(
    parameter int DEPTH = PM_DEPTH,
    parameter int AW    = ADDR_W,
    parameter int DW    = PM_W
) (
    input  wire logic          ref_clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [DW-1:0] rdata_a,
    output logic      [DW-1:0] rdata_b
);
    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [DW-1:0]            ra;
        logic [DW-1:0]            rb;
    } dmmod_ram_s;

    dmmod_ram_s st_r;
    dmmod_ram_s st_nxt;

    // Contents carry no reset: memory is undefined until written
    always_comb begin
        st_nxt    = st_r;
        st_nxt.ra = st_r.mem[raddr_a];
        st_nxt.rb = st_r.mem[raddr_b];
        if (we) begin
            st_nxt.mem[waddr] = wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        st_r <= st_nxt;
    end

    assign rdata_a = st_r.ra;
    assign rdata_b = st_r.rb;
endmodule

// [src/dmmod_wait_ctr.sv]
// Wait-state counter that stretches one external access
`timescale 1ns/1ps
module dmmod_wait_ctr
    import dmmod_pkg::*;
#(
    parameter int W = WAIT_W
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic         start,
    input  wire logic [W-1:0] wait_n,
    output logic              busy,
    output logic              stall,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } dmmod_wait_s;

    dmmod_wait_s st_r;
    dmmod_wait_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (start) begin
            st_nxt.cnt = wait_n;
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Access spans wait_n+1 cycles; the core stalls in all but the last
    assign busy  = (st_r.cnt != '0);
    assign stall = (start && (wait_n != '0)) || (st_r.cnt > 1);
    assign done  = (start && (wait_n == '0)) || (st_r.cnt == 1);
endmodule

// [src/dmmod_decoder.sv]
// Memory map, overlay and wait-state decoder with boot gating
//
// Operation
// - program RAM gives fetch and data read together
// - map pin low, no overlay: program all internal
// - program overlay one or two: upper program half external
// - program overlay address: low bits plus segment bit
// - overlay selects never auto-saved, sequencer ignores them
// - map pin high disables boot and the program overlay; the data overlay still applies
// - map pin high: lower program half external
// - top 32 data words are control registers
// - data overlay one or two: lower data half external
// - data overlay address: low bits plus segment bit
// - internal data one cycle, external uses waits
// - I/O space 2048 words on eleven lines
// - four I/O regions each with 3-bit waits
// - after reset with map pin low boot first, then fetch location zero
// - later resets need no clock settling delay
// - reset clears mode word, stacks, interrupt masks
`timescale 1ns/1ps
module dmmod_decoder
    import dmmod_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 memory_map_select_pin,
    input  wire logic                 bus_request_pin,
    input  wire logic                 boot_done,
    input  wire logic [ADDR_W-1:0]    pm_fetch_addr,
    input  wire logic                 pm_fetch,
    input  wire logic [ADDR_W-1:0]    pm_data_addr,
    input  wire logic                 pm_data_rd,
    input  wire logic                 pm_data_wr,
    input  wire logic [PM_W-1:0]      pm_wdata,
    input  wire logic [ADDR_W-1:0]    dm_addr,
    input  wire logic                 dm_req,
    input  wire logic [IO_ADDR_W-1:0] io_addr,
    input  wire logic                 io_req,
    input  wire logic [REG_AW-1:0]    reg_addr,
    input  wire logic [REG_DW-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [REG_DW-1:0]    reg_rdata,
    output logic      [PM_W-1:0]      pm_fetch_data,
    output logic      [PM_W-1:0]      pm_rdata,
    output logic                      pm_fetch_ext,
    output logic                      pm_data_ext,
    output logic                      dm_internal,
    output logic                      dm_mmr_sel,
    output logic                      ext_pm_sel,
    output logic                      ext_dm_sel,
    output logic                      ext_io_sel,
    output logic      [ADDR_W-1:0]    ext_addr,
    output logic                      core_stall,
    output logic                      ext_done,
    output logic                      boot_req,
    output logic                      core_run,
    output logic                      core_clear
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        dmmod_boot_e   boot;
        logic [1:0]    scnt;
        logic [1:0]    s1;
        logic [1:0]    s2;
        logic [1:0]    s3;
        logic          memory_map_select_pin_q;
        logic          breq_q;
        logic [3:0]    pmovl;
        logic [3:0]    dmovl;
        logic [2:0]    data_wait_count;
        logic [11:0]   iowait;
        logic [7:0]    msw;
        logic          ovl_err;
        logic [15:0]   rdata;
    } dmmod_state_s;

    dmmod_state_s st_r;
    dmmod_state_s st_nxt;

    logic                 pm_ovl_ok;
    logic                 pm_ovl_bad;
    logic                 dm_ovl_ok;
    logic                 dm_ovl_bad;
    logic                 fetch_ext;
    logic                 pdata_ext;
    logic                 pdata_blk;
    logic                 dm_ext;
    logic                 dm_blk;
    logic                 ram_we;
    logic                 wc_busy;
    logic                 wc_stall;
    logic                 wc_done;
    logic                 ext_start;
    logic [2:0]           ext_wait;
    logic [2:0]           io_wait;
    logic                 pm_ext_any;
    logic [ADDR_W-1:0]    pm_ext_src;
    logic [3:0]           pm_ovl_eff;

    // ****************************************
    // Address decode
    // ****************************************
    always_comb begin
        // With the map pin high the program overlay is ignored entirely; the data overlay is not
        pm_ovl_eff = st_r.memory_map_select_pin_q ? OVL_NONE : st_r.pmovl;
        pm_ovl_ok  = (pm_ovl_eff == OVL_ONE) || (pm_ovl_eff == OVL_TWO);
        pm_ovl_bad = (pm_ovl_eff > OVL_TWO);
        dm_ovl_ok  = (st_r.dmovl == OVL_ONE) || (st_r.dmovl == OVL_TWO);
        dm_ovl_bad = (st_r.dmovl > OVL_TWO);
        if (st_r.memory_map_select_pin_q) begin
            fetch_ext = !pm_fetch_addr[13];
            pdata_ext = !pm_data_addr[13];
            pdata_blk = 1'b0;
        end else begin
            fetch_ext = pm_fetch_addr[13] && pm_ovl_ok;
            pdata_ext = pm_data_addr[13] && pm_ovl_ok;
            pdata_blk = pm_data_addr[13] && pm_ovl_bad;
        end
        dm_ext = !dm_addr[13] && dm_ovl_ok;
        dm_blk = !dm_addr[13] && dm_ovl_bad;
    end

    assign pm_fetch_ext = pm_fetch && fetch_ext;
    assign pm_data_ext  = (pm_data_rd || pm_data_wr) && pdata_ext;
    assign dm_mmr_sel   = dm_req && (dm_addr >= DM_MMR_BASE);
    // 0x2000..0x3FDF is always internal; the lower half follows the overlay
    assign dm_internal  = dm_req && !dm_mmr_sel && !dm_ext && !dm_blk;
    assign ram_we       = pm_data_wr && !pdata_ext && !pdata_blk && core_run;

    // ****************************************
    // Program RAM, two reads per cycle
    // ****************************************
    dmmod_pm_ram #(
        .DEPTH (PM_DEPTH),
        .AW    (ADDR_W),
        .DW    (PM_W)
    ) u_dmmod_pm_ram (
        .ref_clk (ref_clk),
        .we      (ram_we),
        .waddr   (pm_data_addr),
        .wdata   (pm_wdata),
        .raddr_a (pm_fetch_addr),
        .raddr_b (pm_data_addr),
        .rdata_a (pm_fetch_data),
        .rdata_b (pm_rdata)
    );

    // ****************************************
    // External bus and wait states
    // ****************************************
    always_comb begin
        case (io_addr[10:9])
            2'd0:    io_wait = st_r.iowait[2:0];
            2'd1:    io_wait = st_r.iowait[5:3];
            2'd2:    io_wait = st_r.iowait[8:6];
            default: io_wait = st_r.iowait[11:9];
        endcase
    end

    // Data access wins the bus over I/O, both over program overlay
    assign ext_start  = !wc_busy && ((dm_req && dm_ext) || io_req);
    assign ext_wait   = (dm_req && dm_ext) ? st_r.data_wait_count : io_wait;
    assign pm_ext_any = pm_fetch_ext || pm_data_ext;
    assign pm_ext_src = pm_data_ext ? pm_data_addr : pm_fetch_addr;

    dmmod_wait_ctr #(
        .W (WAIT_W)
    ) u_dmmod_wait_ctr (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (ext_start),
        .wait_n  (ext_wait),
        .busy    (wc_busy),
        .stall   (wc_stall),
        .done    (wc_done)
    );

    always_comb begin
        ext_dm_sel = dm_req && dm_ext;
        ext_io_sel = !ext_dm_sel && io_req;
        ext_pm_sel = !ext_dm_sel && !ext_io_sel && pm_ext_any;
        ext_addr   = '0;
        if (ext_dm_sel) begin
            ext_addr = {(st_r.dmovl == OVL_TWO), dm_addr[12:0]};
        end else if (ext_io_sel) begin
            // Upper lines have no meaning in I/O cycles; held low
            ext_addr = {3'h0, io_addr};
        end else if (ext_pm_sel) begin
            ext_addr = {(pm_ovl_eff == OVL_TWO), pm_ext_src[12:0]};
        end
    end

    // Program overlay access stalls the core for every cycle that a data or I/O access holds the bus
    assign core_stall = wc_stall || (pm_ext_any && (ext_dm_sel || ext_io_sel));
    assign ext_done   = wc_done;

    // ****************************************
    // Pin sync, boot sequence, registers
    // ****************************************
    always_comb begin
        st_nxt       = st_r;
        st_nxt.s1    = {bus_request_pin, memory_map_select_pin};
        st_nxt.s2    = st_r.s1;
        st_nxt.s3    = st_r.s2;
        st_nxt.rdata = '0;
        if (st_r.s2[0] == st_r.s3[0]) begin
            st_nxt.memory_map_select_pin_q = st_r.s3[0];
        end
        if (st_r.s2[1] == st_r.s3[1]) begin
            st_nxt.breq_q = st_r.s3[1];
        end
        case (st_r.boot)
            DMMOD_SYNC: begin
                // Waits until the synchronised pins have settled; no clock settling wait
                if (st_r.scnt == 2'(SYNC_CYCLES)) begin
                    st_nxt.boot = DMMOD_DECIDE;
                end else begin
                    st_nxt.scnt = st_r.scnt + 2'd1;
                end
            end
            DMMOD_DECIDE: begin
                if (!st_r.breq_q) begin
                    st_nxt.boot = st_r.memory_map_select_pin_q ? DMMOD_RUN : DMMOD_BOOT;
                end
            end
            DMMOD_BOOT: begin
                if (boot_done) begin
                    st_nxt.boot = DMMOD_RUN;
                end
            end
            DMMOD_RUN: begin
                st_nxt.boot = DMMOD_RUN;
            end
            default: begin
                st_nxt.boot = DMMOD_SYNC;
            end
        endcase
        // Bad overlay data accesses are dropped and remembered; fetches are not
        if ((pm_data_wr || pm_data_rd) && pdata_blk || dm_req && dm_blk) begin
            st_nxt.ovl_err = 1'b1;
        end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_OVLERR_BIT]) begin
            st_nxt.ovl_err = 1'b0;
        end
        // Plain software registers; nothing saves them on interrupts
        if (reg_wr) begin
            case (reg_addr)
                REG_PM_OVL: st_nxt.pmovl  = reg_wdata[3:0];
                REG_DM_OVL: st_nxt.dmovl  = reg_wdata[3:0];
                REG_DATA_WAIT_COUNT:  st_nxt.data_wait_count  = reg_wdata[2:0];
                REG_IOWAIT: st_nxt.iowait = reg_wdata[11:0];
                REG_MSW:    st_nxt.msw    = reg_wdata[7:0];
                default:    st_nxt.msw    = st_r.msw;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                REG_PM_OVL: st_nxt.rdata = {12'h000, st_r.pmovl};
                REG_DM_OVL: st_nxt.rdata = {12'h000, st_r.dmovl};
                REG_DATA_WAIT_COUNT:  st_nxt.rdata = {13'h0000, st_r.data_wait_count};
                REG_IOWAIT: st_nxt.rdata = {4'h0, st_r.iowait};
                REG_MSW:    st_nxt.rdata = {8'h00, st_r.msw};
                REG_STATUS: st_nxt.rdata = {12'h000, st_r.ovl_err, st_r.memory_map_select_pin_q,
                                            (st_r.boot == DMMOD_BOOT), (st_r.boot == DMMOD_RUN)};
                default:    st_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_r <= '{boot: DMMOD_SYNC, pmovl: OVL_RST, dmovl: OVL_RST, data_wait_count: DATA_WAIT_COUNT_RST,
                      iowait: IOWAIT_RST, msw: MSW_RST, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata  = st_r.rdata;
    assign boot_req   = (st_r.boot == DMMOD_BOOT);
    assign core_run   = (st_r.boot == DMMOD_RUN);
    // Stacks empty and interrupts masked while the core is not running
    assign core_clear = !core_run;

    // ****************************************
    // Checks
    // ****************************************
    AST_DUAL_READ: assert property (@(posedge ref_clk) disable iff (!resetn)
        (pm_fetch && pm_data_rd && !ram_we && pm_fetch_addr == pm_data_addr)
        |=> (pm_fetch_data == pm_rdata))
        else $error("fetch and data read of one word disagree");

    AST_PM_LOW_INT: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!st_r.memory_map_select_pin_q && pm_fetch && !pm_fetch_addr[13]) |-> !pm_fetch_ext)
        else $error("lower program half went external");

    AST_PM_OVL_A13: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ext_pm_sel && !st_r.memory_map_select_pin_q) |-> (ext_addr == {(st_r.pmovl == OVL_TWO), pm_ext_src[12:0]}))
        else $error("program overlay address wrong");

    AST_MAP_HIGH: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_r.memory_map_select_pin_q && pm_fetch) |-> (pm_fetch_ext == !pm_fetch_addr[13]))
        else $error("map pin high decode wrong");

    AST_DM_REGS: assert property (@(posedge ref_clk) disable iff (!resetn)
        (dm_req && dm_addr[13] && !dm_mmr_sel) |-> (dm_internal && !ext_dm_sel))
        else $error("upper data half not internal");

    AST_DM_WAIT2: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ext_start && ext_dm_sel && st_r.data_wait_count == 3'h2)
        |-> core_stall ##1 core_stall ##1 (!wc_stall && ext_done))
        else $error("data wait states not applied");

    AST_IO_ADDR: assert property (@(posedge ref_clk) disable iff (!resetn)
        ext_io_sel |-> (ext_addr[13:11] == 3'h0 && ext_addr[10:0] == io_addr))
        else $error("I/O address wrong");

    AST_IO_REGION3: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ext_start && ext_io_sel && io_addr[10:9] == 2'd3)
        |-> (ext_wait == st_r.iowait[11:9] && wc_stall == (st_r.iowait[11:9] != 3'h0)))
        else $error("I/O region wait wrong");

    AST_BOOT_FIRST: assert property (@(posedge ref_clk) disable iff (!resetn)
        (boot_req && !boot_done) |=> !core_run)
        else $error("core ran before boot finished");

    AST_RESET_MSW: assert property (@(posedge ref_clk)
        !resetn |=> (st_r.msw == MSW_RST && core_clear && !boot_req))
        else $error("mode word or clear state not reset");

    AST_OVL_SAFE: assert property (@(posedge ref_clk) disable iff (!resetn)
        (pdata_blk && pm_data_wr) |-> (!ram_we ##1 st_r.ovl_err))
        else $error("unsupported overlay reached internal RAM");
endmodule

// [tb/dmmod_ext_model.sv]
// External overlay memory and I/O peripheral seen from the far side of the bus
`timescale 1ns/1ps
module dmmod_ext_model
    import dmmod_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              ext_pm_sel,
    input  wire logic              ext_dm_sel,
    input  wire logic              ext_io_sel,
    input  wire logic [ADDR_W-1:0] ext_addr,
    input  wire logic              ext_done,
    output logic      [ADDR_W-1:0] last_addr,
    output logic      [7:0]        acc_cnt
);
    // Address is latched only when the access completes, as a slow peripheral would
    initial begin
        last_addr = 14'h0000;
        acc_cnt   = 8'h00;
    end
    always @(posedge ref_clk) begin
        if (ext_done === 1'b1 && (ext_dm_sel === 1'b1 || ext_io_sel === 1'b1)) begin
            last_addr <= ext_addr;
            acc_cnt   <= acc_cnt + 8'h01;
        end
    end
endmodule

// [tb/dmmod_decoder_test.sv]
// Self-checking bench of the memory map, overlay and wait-state decoder
`timescale 1ns/1ps
module dmmod_decoder_test
    import dmmod_pkg::*;
;
    logic ref_clk = 0, resetn = 0, mpin = 0, boot_done = 0, pm_fetch = 0, pm_rd = 0, pm_wr = 0;
    logic dm_req = 0, io_req = 0, reg_wr = 0, reg_rd = 0, breq = 0;
    logic [13:0] pm_fa = 14'h0000, pm_da = 14'h0000, dm_addr = 14'h0000;
    logic [10:0] io_addr = 11'h000;
    logic [23:0] pm_wdata = 24'h000000;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [23:0] f_data, p_data;
    logic f_ext, p_ext, dm_int, dm_mmr, e_pm, e_dm, e_io, stall, e_done, boot_req, core_run, core_clear;
    logic [13:0] ext_addr, last_addr;
    logic [7:0]  acc_cnt;
    int fail_count = 0, n_checks = 0, cyc = 0;
    always #50 ref_clk = ~ref_clk;
    dmmod_decoder u_dmmod_decoder (.ref_clk(ref_clk), .resetn(resetn), .memory_map_select_pin(mpin),
        .bus_request_pin(breq), .boot_done(boot_done), .pm_fetch_addr(pm_fa), .pm_fetch(pm_fetch),
        .pm_data_addr(pm_da), .pm_data_rd(pm_rd), .pm_data_wr(pm_wr), .pm_wdata(pm_wdata),
        .dm_addr(dm_addr), .dm_req(dm_req), .io_addr(io_addr), .io_req(io_req), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pm_fetch_data(f_data), .pm_rdata(p_data), .pm_fetch_ext(f_ext), .pm_data_ext(p_ext),
        .dm_internal(dm_int), .dm_mmr_sel(dm_mmr), .ext_pm_sel(e_pm), .ext_dm_sel(e_dm),
        .ext_io_sel(e_io), .ext_addr(ext_addr), .core_stall(stall), .ext_done(e_done),
        .boot_req(boot_req), .core_run(core_run), .core_clear(core_clear));
    dmmod_ext_model u_dmmod_ext_model (.ref_clk(ref_clk), .ext_pm_sel(e_pm), .ext_dm_sel(e_dm),
        .ext_io_sel(e_io), .ext_addr(ext_addr), .ext_done(e_done), .last_addr(last_addr), .acc_cnt(acc_cnt));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge ref_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk); reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [15:0] exp);
        @(posedge ref_clk); reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk); reg_rd <= 1'b0;
        @(negedge ref_clk); chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    endtask
    // Reset is held for several cycles and clears the synchroniser, which fills only after release; the clock never stops
    task automatic do_reset(logic pin);
        int i;
        @(posedge ref_clk); resetn <= 1'b0; mpin <= pin; breq <= 1'b1;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk); chk("core_clear", 24'h1, {23'h0, core_clear});
        @(posedge ref_clk); resetn <= 1'b1;
        // A pending bus request holds off both boot and run
        repeat (8) @(negedge ref_clk);
        chk("breq_hold", 24'h0, {22'h0, boot_req, core_run});
        @(posedge ref_clk); breq <= 1'b0;
        for (i = 0; i < 12 && boot_req !== 1'b1 && core_run !== 1'b1; i++) @(negedge ref_clk);
        chk("boot_req", {23'h0, !pin}, {23'h0, boot_req});
        chk("core_run", {23'h0, pin}, {23'h0, core_run});
        @(posedge ref_clk); boot_done <= 1'b1;
        @(posedge ref_clk); boot_done <= 1'b0;
        for (i = 0; i < 6 && core_run !== 1'b1; i++) @(negedge ref_clk);
        chk("core_run", 24'h1, {23'h0, core_run});
    endtask
    task automatic pm_probe(logic [13:0] a, logic ext, logic [13:0] ea);
        @(posedge ref_clk); pm_fa <= a; pm_fetch <= 1'b1;
        @(negedge ref_clk); chk("pm_fetch_ext", {23'h0, ext}, {23'h0, f_ext});
        chk("ext_addr", {10'h0, ea}, {10'h0, ext_addr});
        chk("ext_pm_sel", {23'h0, ext}, {23'h0, e_pm});
        @(posedge ref_clk); pm_fetch <= 1'b0;
    endtask
    task automatic dm_probe(logic [13:0] a, logic in, logic mmr);
        @(posedge ref_clk); dm_addr <= a; dm_req <= 1'b1;
        @(negedge ref_clk); chk("dm_internal", {23'h0, in}, {23'h0, dm_int});
        chk("dm_mmr_sel", {23'h0, mmr}, {23'h0, dm_mmr});
        @(posedge ref_clk); dm_req <= 1'b0;
    endtask
    // Counts stall cycles until completion and checks the address shown on the bus
    task automatic ext_acc(logic io, logic [13:0] a, int n, logic [13:0] ea);
        int k;
        @(posedge ref_clk);
        if (io) begin io_addr <= a[10:0]; io_req <= 1'b1; end
        else begin dm_addr <= a; dm_req <= 1'b1; end
        @(negedge ref_clk); chk("ext_addr", {10'h0, ea}, {10'h0, ext_addr});
        for (k = 0; k < 20 && e_done !== 1'b1; k++) @(negedge ref_clk);
        chk("wait_cycles", n, k);
        chk("core_stall", 24'h0, {23'h0, stall});
        @(posedge ref_clk); io_req <= 1'b0; dm_req <= 1'b0;
        @(negedge ref_clk); chk("model_addr", {10'h0, ea}, {10'h0, last_addr});
    endtask
    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin fail_count++; complete_run(); end
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        do_reset(1'b0);
        rd(REG_MSW, 16'h0000);
        rd(REG_STATUS, 16'h0001);
        rd(4'h9, 16'h0000);
        $display("Test reset_boot done");
        @(posedge ref_clk); pm_wr <= 1'b1; pm_da <= 14'h0010; pm_wdata <= 24'hA5A5A5;
        @(posedge ref_clk); pm_da <= 14'h0011; pm_wdata <= 24'h5A5A5A;
        @(posedge ref_clk); pm_wr <= 1'b0; pm_rd <= 1'b1; pm_fa <= 14'h0010; pm_fetch <= 1'b1;
        @(posedge ref_clk); pm_rd <= 1'b0; pm_fetch <= 1'b0;
        @(negedge ref_clk); chk("fetch_data", 24'hA5A5A5, f_data);
        chk("pm_rdata", 24'h5A5A5A, p_data);
        @(posedge ref_clk); pm_rd <= 1'b1; pm_fetch <= 1'b1; pm_fa <= 14'h0011;
        @(posedge ref_clk); pm_rd <= 1'b0; pm_fetch <= 1'b0;
        @(negedge ref_clk); chk("dual_read", 24'h5A5A5A, f_data);
        pm_probe(14'h3FFF, 1'b0, 14'h0000);
        wr(REG_PM_OVL, 16'h0001);
        pm_probe(14'h2005, 1'b1, 14'h0005);
        pm_probe(14'h1FFF, 1'b0, 14'h0000);
        wr(REG_PM_OVL, 16'h0002);
        pm_probe(14'h3ABC, 1'b1, 14'h3ABC);
        wr(REG_PM_OVL, 16'h0003);
        pm_probe(14'h2005, 1'b0, 14'h0000);
        @(posedge ref_clk); pm_wr <= 1'b1; pm_da <= 14'h2005;
        @(negedge ref_clk); chk("pm_data_ext", 24'h0, {23'h0, p_ext});
        @(posedge ref_clk); pm_wr <= 1'b0;
        rd(REG_STATUS, 16'h0009);
        wr(REG_STATUS, 16'h0008);
        rd(REG_STATUS, 16'h0001);
        rd(REG_PM_OVL, 16'h0003);
        wr(REG_PM_OVL, 16'h0000);
        $display("Test program_map done");
        dm_probe(14'h3FE5, 1'b0, 1'b1);
        dm_probe(14'h3FDF, 1'b1, 1'b0);
        dm_probe(14'h0100, 1'b1, 1'b0);
        wr(REG_DATA_WAIT_COUNT, 16'h0002);
        wr(REG_DM_OVL, 16'h0002);
        dm_probe(14'h2000, 1'b1, 1'b0);
        ext_acc(1'b0, 14'h0100, 2, 14'h2100);
        wr(REG_DM_OVL, 16'h0001);
        ext_acc(1'b0, 14'h1FFF, 2, 14'h1FFF);
        $display("Test data_map done");
        wr(REG_IOWAIT, 16'h08D1);
        rd(REG_IOWAIT, 16'h08D1);
        ext_acc(1'b1, 14'h01FF, 1, 14'h01FF);
        ext_acc(1'b1, 14'h0200, 2, 14'h0200);
        ext_acc(1'b1, 14'h05FF, 3, 14'h05FF);
        ext_acc(1'b1, 14'h07FF, 4, 14'h07FF);
        chk("model_count", 24'h6, {16'h0, acc_cnt});
        $display("Test io_waits done");
        wr(REG_MSW, 16'h00A5);
        rd(REG_MSW, 16'h00A5);
        // Software keeps the program overlay at zero in this mode
        do_reset(1'b1);
        rd(REG_MSW, 16'h0000);
        pm_probe(14'h0010, 1'b1, 14'h0010);
        pm_probe(14'h2000, 1'b0, 14'h0000);
        $display("Test compat_map done");
        complete_run();
    end
endmodule
